//--- inc/ppea_pkg.sv
// Types shared by the paged EEPROM host modules.
// Assumes the timing header is on the include path.
`include "ppea_regs.svh"

package ppea_pkg;

    typedef enum logic [1:0] {op_read, op_write, op_lock_on, op_lock_off} ppea_op_t;

    typedef enum logic [2:0] {
        st_lockout, st_idle, st_seq, st_wr, st_load, st_rd, st_poll
    } ppea_state_t;

    typedef enum logic [1:0] {cyc_idle, cyc_setup, cyc_active, cyc_hold} ppea_phase_t;

endpackage

//--- inc/ppea_regs.svh
// Timing counts and fixed addresses for the paged EEPROM host.
// Assumes a 100 MHz system clock; included by the package and the modules.
`ifndef PPEA_REGS_SVH
`define PPEA_REGS_SVH

`define PPEA_CLK_MHZ      100
`define PPEA_T_WP_NS      100
`define PPEA_T_ACC_NS     120
`define PPEA_T_OEHP_NS    150
`define PPEA_T_BLC_US     150
`define PPEA_T_WC_MS      10
`define PPEA_T_LOCK_MS    5

// Least times round up, longest times round down
`define PPEA_WP_CYC       ((`PPEA_T_WP_NS * `PPEA_CLK_MHZ + 999) / 1000)
`define PPEA_ACC_CYC      ((`PPEA_T_ACC_NS * `PPEA_CLK_MHZ + 999) / 1000)
`define PPEA_REC_CYC      ((`PPEA_T_OEHP_NS * `PPEA_CLK_MHZ + 999) / 1000)
`define PPEA_CYC_LEN      (1 + `PPEA_WP_CYC + `PPEA_REC_CYC)
`define PPEA_BLC_CYC      (`PPEA_T_BLC_US * `PPEA_CLK_MHZ)
`define PPEA_WC_CYC       (`PPEA_T_WC_MS * 1000 * `PPEA_CLK_MHZ)
`define PPEA_LOCK_CYC     ((`PPEA_T_LOCK_MS * 1000 * `PPEA_CLK_MHZ + 999) / 1000 * 1000)

`define PPEA_ID_BASE      17'h1FF80
`define PPEA_PAGE_LSB     7
`define PPEA_ADDR_MSB     16

`endif

//--- logic/ppea_host.sv
// Host controller for a paged parallel EEPROM: reads, page writes,
// guarded writes, lock commands and end-of-write polling.
// Assumes the memory pins are wired straight to the device.
`timescale 1ns/1ps
`include "ppea_regs.svh"

// Functional notes
// - Next byte loaded within 150 us
// - Page address constant across page load
// - Poll at one constant address, strobe framed
// - Locked writes need the sequence first
// - Command sequences use page write timing
module ppea_host
    import ppea_pkg::*;
#(
    parameter logic [23:0] LOCK_CYC    = 24'(`PPEA_LOCK_CYC),
    parameter logic [23:0] WC_CYC      = 24'(`PPEA_WC_CYC),
    parameter logic [23:0] BLC_CYC     = 24'(`PPEA_BLC_CYC),
    parameter logic [16:0] SEQ_ADDR0   = 17'h00001,
    parameter logic [16:0] SEQ_ADDR1   = 17'h00002,
    parameter logic [16:0] SEQ_ADDR2   = 17'h00003,
    parameter logic [7:0]  SEQ_DATA0   = 8'h11,
    parameter logic [7:0]  SEQ_DATA1   = 8'h22,
    parameter logic [7:0]  SEQ_ON_LAST = 8'h33,
    parameter logic [7:0]  SEQ_OFF_LAST = 8'h44
)(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Command port
    input  wire logic        cmd_valid_in,
    output logic             cmd_ready_out,
    input  wire ppea_op_t    cmd_op_in,
    input  wire logic [16:0] cmd_addr_in,
    input  wire logic [7:0]  cmd_data_in,
    input  wire logic        cmd_last_in,
    input  wire logic        cmd_id_in,
    input  wire logic        cmd_guard_in,
    // Answers and status
    output logic             rd_valid_out,
    output logic [7:0]       rd_data_out,
    output logic             done_out,
    output logic             timeout_out,
    output logic             busy_out,
    // Memory pins
    output logic [16:0]      mem_addr_out,
    output logic [7:0]       mem_dq_out,
    output logic             mem_dq_oe_out,
    input  wire logic [7:0]  mem_dq_in,
    output logic             mem_ce_n_out,
    output logic             mem_oe_n_out,
    output logic             mem_we_n_out,
    output logic             mem_id_hv_out
);

    function automatic logic [16:0] map_addr(input logic [16:0] a, input logic id);
        map_addr = id ? (`PPEA_ID_BASE | {10'h000, a[6:0]}) : a;
    endfunction

    function automatic logic same_page(input logic [16:0] a, input logic [16:0] b);
        same_page = a[`PPEA_ADDR_MSB:`PPEA_PAGE_LSB] == b[`PPEA_ADDR_MSB:`PPEA_PAGE_LSB];
    endfunction

    ppea_state_t state, next_state;
    logic [23:0] tmr;
    logic [23:0] gap;
    logic [1:0]  seq_idx;
    logic        seq_off;
    logic        has_data;
    logic        page_last;
    logic [16:0] last_addr;
    logic [7:0]  last_data;
    logic        last_id;
    logic        have_prev;
    logic        prev_b6;
    logic        cyc_start;
    logic        cyc_write;
    logic [16:0] cyc_addr;
    logic [7:0]  cyc_data;
    logic        cyc_id;
    logic        cyc_done;
    logic [7:0]  cyc_rdata;
    logic [9:0]  page_first;
    logic        loaded;
    logic [23:0] we_gap;

    wire         idle_fire = (state == st_idle) && cmd_valid_in;
    wire         lock_op   = (cmd_op_in == op_lock_on) || (cmd_op_in == op_lock_off);
    wire         need_seq  = lock_op || (cmd_op_in == op_write && cmd_guard_in);
    wire  [16:0] cmd_map   = map_addr(cmd_addr_in, cmd_id_in);
    wire         gap_ok    = gap < BLC_CYC - 24'(`PPEA_CYC_LEN);
    wire         load_ok   = (state == st_load) && (cmd_op_in == op_write) && !cmd_guard_in
                             && !page_last && (cmd_id_in == last_id)
                             && same_page(cmd_map, last_addr) && gap_ok;
    wire         load_fire = load_ok && cmd_valid_in;
    wire         page_end  = page_last || (gap >= BLC_CYC);
    wire         seq_step  = (state == st_seq) && cyc_done;
    wire         seq_next  = seq_step && (seq_idx != 2'd2);
    wire         seq_data  = seq_step && (seq_idx == 2'd2) && has_data;
    wire         poll_go   = (state == st_load) && !load_fire && page_end;
    wire         poll_done = (state == st_poll) && cyc_done;
    wire         poll_ok   = poll_done && have_prev && (cyc_rdata[6] == prev_b6)
                             && (!has_data || cyc_rdata[7] == last_data[7]);
    wire         poll_late = poll_done && !poll_ok && (tmr >= WC_CYC);
    wire         poll_more = poll_done && !poll_ok && !poll_late;
    wire         seq_word  = (idle_fire && need_seq) || seq_next;
    wire  [1:0]  idx_sel   = idle_fire ? 2'd0 : seq_idx + 2'd1;
    wire         off_sel   = idle_fire ? (cmd_op_in == op_lock_off) : seq_off;
    wire         cmd_word  = (idle_fire && !need_seq) || load_fire;
    wire  [16:0] seq_a     = (idx_sel == 2'd0) ? SEQ_ADDR0 :
                             (idx_sel == 2'd1) ? SEQ_ADDR1 : SEQ_ADDR2;
    wire  [7:0]  seq_d     = (idx_sel == 2'd0) ? SEQ_DATA0 :
                             (idx_sel == 2'd1) ? SEQ_DATA1 :
                             off_sel ? SEQ_OFF_LAST : SEQ_ON_LAST;

    assign cmd_ready_out = (state == st_idle) || load_ok;
    assign busy_out      = state != st_idle;
    assign cyc_start     = idle_fire || load_fire || seq_next || seq_data
                           || poll_go || poll_more;
    assign cyc_write     = !(poll_go || poll_more || (idle_fire && cmd_op_in == op_read));
    assign cyc_addr      = seq_word ? seq_a : cmd_word ? cmd_map : last_addr;
    assign cyc_data      = seq_word ? seq_d : cmd_word ? cmd_data_in : last_data;
    assign cyc_id        = seq_word ? 1'b0 : cmd_word ? cmd_id_in : last_id;

    always_comb
    begin
        next_state = state;
        unique case (state)
            st_lockout: if (tmr >= LOCK_CYC) next_state = st_idle;
            st_idle:
                if (idle_fire)
                    next_state = (cmd_op_in == op_read) ? st_rd : need_seq ? st_seq : st_wr;
            st_seq:     if (seq_step && seq_idx == 2'd2) next_state = has_data ? st_wr : st_load;
            st_wr:      if (cyc_done) next_state = st_load;
            st_load:
                if (load_fire)
                    next_state = st_wr;
                else if (poll_go)
                    next_state = st_poll;
            st_rd:      if (cyc_done) next_state = st_idle;
            st_poll:    if (poll_ok || poll_late) next_state = st_idle;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state <= st_lockout;
            tmr   <= 24'h000000;
            gap   <= 24'h000000;
        end
        else
        begin
            state <= next_state;
            tmr   <= poll_go ? 24'h000000 : (tmr == 24'hFFFFFF) ? tmr : tmr + 24'h000001;
            gap   <= (cyc_start && cyc_write) ? 24'h000000 :
                     (gap == 24'hFFFFFF) ? gap : gap + 24'h000001;
        end
    end

    // Page context, latched per accepted command or page byte
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            seq_idx   <= 2'd0;
            seq_off   <= 1'b0;
            has_data  <= 1'b0;
            page_last <= 1'b0;
            last_addr <= 17'h00000;
            last_data <= 8'h00;
            last_id   <= 1'b0;
        end
        else if (idle_fire || load_fire)
        begin
            seq_idx   <= 2'd0;
            seq_off   <= idle_fire ? (cmd_op_in == op_lock_off) : seq_off;
            has_data  <= idle_fire ? (cmd_op_in == op_write) : has_data;
            page_last <= cmd_last_in || (idle_fire && lock_op);
            last_addr <= cmd_map;
            last_data <= cmd_data_in;
            last_id   <= cmd_id_in;
        end
        else if (seq_next)
            seq_idx <= seq_idx + 2'd1;
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            have_prev    <= 1'b0;
            prev_b6      <= 1'b0;
            rd_valid_out <= 1'b0;
            rd_data_out  <= 8'h00;
            done_out     <= 1'b0;
            timeout_out  <= 1'b0;
            page_first   <= 10'h000;
            loaded       <= 1'b0;
            we_gap       <= 24'h000000;
        end
        else
        begin
            have_prev    <= !poll_go && (have_prev || poll_done);
            prev_b6      <= poll_done ? cyc_rdata[6] : prev_b6;
            rd_valid_out <= (state == st_rd) && cyc_done;
            rd_data_out  <= ((state == st_rd) && cyc_done) ? cyc_rdata : rd_data_out;
            done_out     <= poll_ok;
            timeout_out  <= poll_late || (timeout_out && !idle_fire);
            page_first   <= idle_fire ? cmd_map[`PPEA_ADDR_MSB:`PPEA_PAGE_LSB] : page_first;
            loaded       <= load_fire || (loaded && !idle_fire);
            we_gap       <= mem_we_n_out ? we_gap + {23'h000000, !(&we_gap)} : 24'h000000;
        end
    end

    ppea_pin_cycle u_cycle (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .start_in  (cyc_start),
        .write_in  (cyc_write),
        .addr_in   (cyc_addr),
        .data_in   (cyc_data),
        .id_in     (cyc_id),
        .done_out  (cyc_done),
        .rdata_out (cyc_rdata),
        .addr_out  (mem_addr_out),
        .dq_out    (mem_dq_out),
        .dq_oe_out (mem_dq_oe_out),
        .dq_in     (mem_dq_in),
        .ce_n_out  (mem_ce_n_out),
        .oe_n_out  (mem_oe_n_out),
        .we_n_out  (mem_we_n_out),
        .id_hv_out (mem_id_hv_out)
    );

    byte_window_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(mem_we_n_out) && loaded |-> we_gap < BLC_CYC)
        else $error("page byte loaded after the byte load window");

    page_fixed_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(mem_we_n_out) && (state == st_wr)
        |-> mem_addr_out[`PPEA_ADDR_MSB:`PPEA_PAGE_LSB] == page_first)
        else $error("page byte outside the page being loaded");

    poll_addr_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (poll_go || poll_more) |-> !cyc_write && cyc_addr == last_addr)
        else $error("poll read not at the constant last address");

    guard_order_a: assert property (@(posedge clk_in) disable iff (rst_in)
        seq_data |-> $past(seq_idx) == 2'd2 && cyc_addr == last_addr)
        else $error("guarded byte issued before full enable sequence");

    seq_timing_a: assert property (@(posedge clk_in) disable iff (rst_in)
        seq_next |-> gap < BLC_CYC && cyc_write)
        else $error("command sequence write outside page timing");

    lockout_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (state == st_lockout) |-> !cyc_start && cmd_ready_out == 1'b0)
        else $error("access during power-on lockout");

    poll_end_a: assert property (@(posedge clk_in) disable iff (rst_in)
        poll_ok |=> done_out && !busy_out ##1 !done_out)
        else $error("poll completion not reported for one cycle");

    page_cov: cover property (@(posedge clk_in) disable iff (rst_in) load_fire ##[1:200] poll_ok);
    guard_cov: cover property (@(posedge clk_in) disable iff (rst_in) seq_data);
    late_cov: cover property (@(posedge clk_in) disable iff (rst_in) poll_late);
    read_cov: cover property (@(posedge clk_in) disable iff (rst_in) rd_valid_out);

endmodule

//--- logic/ppea_pin_cycle.sv
// One read or write cycle on the memory pins, strobes from flip-flops.
// Assumes start_in only while idle or in the cycle that done_out is high.
`timescale 1ns/1ps
`include "ppea_regs.svh"

module ppea_pin_cycle
    import ppea_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Request
    input  wire logic        start_in,
    input  wire logic        write_in,
    input  wire logic [16:0] addr_in,
    input  wire logic [7:0]  data_in,
    input  wire logic        id_in,
    output logic             done_out,
    output logic [7:0]       rdata_out,
    // Memory pins
    output logic [16:0]      addr_out,
    output logic [7:0]       dq_out,
    output logic             dq_oe_out,
    input  wire logic [7:0]  dq_in,
    output logic             ce_n_out,
    output logic             oe_n_out,
    output logic             we_n_out,
    output logic             id_hv_out
);

    ppea_phase_t phase;
    logic [4:0]  cnt;
    logic        wr;
    logic        id;

    wire         free   = (phase == cyc_idle) || done_out;
    wire         take   = start_in && free;
    wire  [4:0]  act_end = wr ? 5'(`PPEA_WP_CYC - 1) : 5'(`PPEA_ACC_CYC - 1);
    wire         act_last = (phase == cyc_active) && (cnt == act_end);

    assign done_out  = (phase == cyc_hold) && (cnt == 5'(`PPEA_REC_CYC - 1));
    assign dq_oe_out = wr && (phase != cyc_idle);
    assign id_hv_out = id && (phase != cyc_idle);

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            phase    <= cyc_idle;
            cnt      <= 5'h00;
            wr       <= 1'b0;
            id       <= 1'b0;
            addr_out <= 17'h00000;
            dq_out   <= 8'h00;
        end
        else if (take)
        begin
            phase    <= cyc_setup;
            cnt      <= 5'h00;
            wr       <= write_in;
            id       <= id_in;
            addr_out <= addr_in;
            dq_out   <= data_in;
        end
        else if (done_out)
            phase <= cyc_idle;
        else if (phase == cyc_setup)
            phase <= cyc_active;
        else if (act_last)
        begin
            phase <= cyc_hold;
            cnt   <= 5'h00;
        end
        else if (phase != cyc_idle)
            cnt <= cnt + 5'h01;
    end

    // Both strobes fall together and rise together around the pulse
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ce_n_out  <= 1'b1;
            oe_n_out  <= 1'b1;
            we_n_out  <= 1'b1;
            rdata_out <= 8'h00;
        end
        else if (phase == cyc_setup)
        begin
            ce_n_out <= 1'b0;
            oe_n_out <= wr;
            we_n_out <= !wr;
        end
        else if (act_last)
        begin
            ce_n_out <= 1'b1;
            oe_n_out <= 1'b1;
            we_n_out <= 1'b1;
            if (!wr)
                rdata_out <= dq_in;
        end
    end

    write_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !we_n_out |-> oe_n_out && !ce_n_out)
        else $error("write strobe low while output gate low or chip deselected");

    pulse_width_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(we_n_out) |-> ##9 !we_n_out ##1 we_n_out)
        else $error("write pulse not exactly ten cycles");

    read_frame_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(oe_n_out) && we_n_out |-> oe_n_out [*8] ##1 !dq_oe_out)
        else $error("read gate high time too short or bus driven after read");

endmodule

//--- testbench/ppea_eeprom_model.sv
// Behavioural model of the paged EEPROM seen from its pins.
// Assumes the bench clock as its time base; host strobes change on that clock.
`timescale 1ns/1ps

module ppea_eeprom_model #(
    parameter int          WIN_CYC   = 200,
    parameter int          PROG_CYC  = 150,
    parameter int          SLOW_CYC  = 600,
    parameter int          LOCK_CYC  = 40,
    parameter logic [16:0] SEQ_ADDR0 = 17'h00001,
    parameter logic [16:0] SEQ_ADDR1 = 17'h00002,
    parameter logic [16:0] SEQ_ADDR2 = 17'h00003,
    parameter logic [7:0]  SEQ_DATA0 = 8'h11,
    parameter logic [7:0]  SEQ_DATA1 = 8'h22,
    parameter logic [7:0]  SEQ_ON    = 8'h33,
    parameter logic [7:0]  SEQ_OFF   = 8'h44
)(
    // Time base and mode
    input  wire logic        clk_in,
    input  wire logic        slow_in,
    // Memory pins
    input  wire logic [16:0] addr_in,
    input  wire logic [7:0]  dq_in,
    input  wire logic        ce_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        we_n_in,
    input  wire logic        id_hv_in,
    output logic [7:0]       dq_out,
    output logic             dq_oe_out
);
    logic [7:0]   arr [0:131071];
    logic [7:0]   id_arr [0:127];
    logic [7:0]   pg [0:127];
    logic [127:0] used;
    logic [16:0]  wa;
    logic [9:0]   pa;
    logic [7:0]   wd;
    logic [7:0]   last_d;
    logic [1:0]   seq;
    logic [1:0]   lk_pend;
    logic         act;
    logic         rd_q;
    logic         tog;
    logic         lock;
    logic         loading;
    logic         pid;
    int           win;
    int           prog;
    int           up;
    int           act_n;

    wire wr_cond = !ce_n_in && !we_n_in && oe_n_in;
    wire rd_cond = !ce_n_in && !oe_n_in && we_n_in;
    wire busy    = loading || prog > 0;
    wire hit_id  = id_hv_in && addr_in >= 17'h1FF80;

    assign dq_oe_out = rd_cond;
    // Status bits while busy, array otherwise
    assign dq_out = busy ? {~last_d[7], tog, last_d[5:0]} :
                    hit_id ? id_arr[addr_in[6:0]] : arr[addr_in];

    initial
    begin
        for (int i = 0; i < 131072; i++) arr[i] = 8'hFF;
        for (int i = 0; i < 128; i++) id_arr[i] = 8'hFF;
        used = '0; seq = 0; lk_pend = 0; act = 0; rd_q = 0; tog = 0; pid = 0;
        lock = 0;
        loading = 0; win = 0; prog = 0; up = 0; act_n = 0; last_d = 8'h00;
    end

    always @(posedge clk_in)
    begin
        if (up < LOCK_CYC) up <= up + 1;
        rd_q <= rd_cond;
        act  <= wr_cond;
        if (rd_cond && !rd_q && busy) tog <= !tog;
        if (wr_cond)
        begin
            if (!act) wa <= addr_in;
            act_n <= act ? act_n + 1 : 1;
            wd <= dq_in;
        end
        // Short pulses, lockout and programming block a load
        if (act && !wr_cond && act_n >= 2 && up >= LOCK_CYC && prog == 0)
        begin
            if (seq == 0 && wa == SEQ_ADDR0 && wd == SEQ_DATA0) seq <= 1;
            else if (seq == 1 && wa == SEQ_ADDR1 && wd == SEQ_DATA1) seq <= 2;
            else if (seq == 2 && wa == SEQ_ADDR2 && (wd == SEQ_ON || wd == SEQ_OFF))
            begin
                seq <= 3;
                lk_pend <= (wd == SEQ_ON) ? 2'd1 : 2'd2;
            end
            else
            begin
                pg[wa[6:0]] <= wd;
                used[wa[6:0]] <= 1'b1;
                pa <= wa[16:7];
                pid <= id_hv_in;
                last_d <= wd;
            end
            loading <= 1'b1;
            win <= 0;
        end
        else if (loading)
        begin
            win <= win + 1;
            if (win == WIN_CYC - 1)
            begin
                loading <= 1'b0;
                prog <= slow_in ? SLOW_CYC : PROG_CYC;
                if (!lock || seq == 3)
                    for (int i = 0; i < 128; i++)
                        if (used[i])
                        begin
                            if (pid) id_arr[i] <= pg[i];
                            else arr[{pa, 7'(i)}] <= pg[i];
                        end
                if (lk_pend == 2'd1) lock <= 1'b1;
                if (lk_pend == 2'd2) lock <= 1'b0;
                seq <= 0;
                lk_pend <= 0;
                used <= '0;
            end
        end
        else if (prog > 0) prog <= prog - 1;
    end
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the paged EEPROM host with a device model.
// Assumes shortened lockout, poll limit and byte window parameters.
`timescale 1ns/1ps

module testbench;
    import ppea_pkg::*;

    logic        clk_in;
    logic        rst_in;
    logic        cmd_valid_in;
    logic        cmd_ready_out;
    ppea_op_t    cmd_op_in;
    logic [16:0] cmd_addr_in;
    logic [7:0]  cmd_data_in;
    logic        cmd_last_in;
    logic        cmd_id_in;
    logic        cmd_guard_in;
    logic        rd_valid_out;
    logic [7:0]  rd_data_out;
    logic        done_out;
    logic        timeout_out;
    logic        busy_out;
    logic [16:0] mem_addr_out;
    logic [7:0]  mem_dq_out;
    logic        mem_dq_oe_out;
    logic [7:0]  mem_dq_in;
    logic        mem_ce_n_out;
    logic        mem_oe_n_out;
    logic        mem_we_n_out;
    logic        mem_id_hv_out;
    logic [7:0]  dev_dq;
    logic        dev_oe;
    logic [7:0]  bus_last;
    logic        slow;
    int          err_total;
    int          checks_done;

    // Undriven bus shows the inverse of its last level
    assign mem_dq_in = dev_oe ? dev_dq : mem_dq_oe_out ? mem_dq_out : ~bus_last;
    always @(posedge clk_in) bus_last <= mem_dq_in;

    ppea_host #(.LOCK_CYC(24'd50), .WC_CYC(24'd400), .BLC_CYC(24'd200)) u_dut (
        .clk_in(clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in),
        .cmd_ready_out(cmd_ready_out), .cmd_op_in(cmd_op_in), .cmd_addr_in(cmd_addr_in),
        .cmd_data_in(cmd_data_in), .cmd_last_in(cmd_last_in), .cmd_id_in(cmd_id_in),
        .cmd_guard_in(cmd_guard_in), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
        .done_out(done_out), .timeout_out(timeout_out), .busy_out(busy_out),
        .mem_addr_out(mem_addr_out), .mem_dq_out(mem_dq_out), .mem_dq_oe_out(mem_dq_oe_out),
        .mem_dq_in(mem_dq_in), .mem_ce_n_out(mem_ce_n_out), .mem_oe_n_out(mem_oe_n_out),
        .mem_we_n_out(mem_we_n_out), .mem_id_hv_out(mem_id_hv_out));

    ppea_eeprom_model u_mem (
        .clk_in(clk_in), .slow_in(slow), .addr_in(mem_addr_out), .dq_in(mem_dq_in),
        .ce_n_in(mem_ce_n_out), .oe_n_in(mem_oe_n_out), .we_n_in(mem_we_n_out),
        .id_hv_in(mem_id_hv_out), .dq_out(dev_dq), .dq_oe_out(dev_oe));

    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic send(input ppea_op_t op, input logic [16:0] a, input logic [7:0] d,
                        input logic last, input logic id, input logic guard);
        int n;
        n = 0;
        @(posedge clk_in);
        cmd_valid_in <= 1'b1;
        cmd_op_in    <= op;
        cmd_addr_in  <= a;
        cmd_data_in  <= d;
        cmd_last_in  <= last;
        cmd_id_in    <= id;
        cmd_guard_in <= guard;
        do
        begin
            @(negedge clk_in);
            n++;
        end while (cmd_ready_out !== 1'b1 && n < 3000);
        chk("cmd_ready", 17'(cmd_ready_out), 17'h1);
        @(posedge clk_in);
        cmd_valid_in <= 1'b0;
    endtask

    // Waits for the end of a write; returns cycles taken
    task automatic wait_done(input logic exp_to, output int n);
        n = 0;
        do
        begin
            @(negedge clk_in);
            n++;
        end while (done_out !== 1'b1 && timeout_out !== 1'b1 && n < 3000);
        chk("timeout", 17'(timeout_out), 17'(exp_to));
        chk("done", 17'(done_out), 17'(!exp_to));
    endtask

    task automatic rdchk(input logic [16:0] a, input logic id, input logic [7:0] exp);
        int n;
        n = 0;
        send(op_read, a, 8'h00, 1'b0, id, 1'b0);
        do
        begin
            @(negedge clk_in);
            n++;
        end while (rd_valid_out !== 1'b1 && n < 100);
        chk("rd_valid", 17'(rd_valid_out), 17'h1);
        chk("rd_data", {9'h000, rd_data_out}, {9'h000, exp});
    endtask

    task automatic wr(input logic [16:0] a, input logic [7:0] d, input logic guard);
        int n;
        send(op_write, a, d, 1'b1, 1'b0, guard);
        wait_done(1'b0, n);
    endtask

    task automatic t_page;
        int n;
        send(op_write, 17'h00185, 8'h5A, 1'b0, 1'b0, 1'b0);
        send(op_write, 17'h00182, 8'h3C, 1'b0, 1'b0, 1'b0);
        send(op_write, 17'h00185, 8'h96, 1'b1, 1'b0, 1'b0);
        @(posedge clk_in);
        cmd_valid_in <= 1'b1;
        cmd_op_in    <= op_read;
        repeat (5) @(negedge clk_in);
        chk("busy_refuse", 17'(cmd_ready_out), 17'h0);
        @(posedge clk_in);
        cmd_valid_in <= 1'b0;
        wait_done(1'b0, n);
        chk("poll_wait", 17'(n >= 300), 17'h1);
        rdchk(17'h00185, 1'b0, 8'h96);
        rdchk(17'h00182, 1'b0, 8'h3C);
        rdchk(17'h00183, 1'b0, 8'hFF);
    endtask

    task automatic t_window;
        int n;
        send(op_write, 17'h00300, 8'h81, 1'b0, 1'b0, 1'b0);
        wait_done(1'b0, n);
        rdchk(17'h00300, 1'b0, 8'h81);
    endtask

    task automatic t_slow;
        int n;
        slow <= 1'b1;
        send(op_write, 17'h00400, 8'hC3, 1'b1, 1'b0, 1'b0);
        wait_done(1'b1, n);
        slow <= 1'b0;
        repeat (700) @(posedge clk_in);
        rdchk(17'h00400, 1'b0, 8'hC3);
        chk("timeout_clear", 17'(timeout_out), 17'h0);
    endtask

    task automatic t_lock;
        int n;
        send(op_lock_on, 17'h00001, 8'h00, 1'b1, 1'b0, 1'b0);
        wait_done(1'b0, n);
        wr(17'h00500, 8'hA5, 1'b0);
        rdchk(17'h00500, 1'b0, 8'hFF);
        wr(17'h00500, 8'hA5, 1'b1);
        rdchk(17'h00500, 1'b0, 8'hA5);
        rdchk(17'h00001, 1'b0, 8'hFF);
        send(op_lock_off, 17'h00001, 8'h00, 1'b1, 1'b0, 1'b0);
        wait_done(1'b0, n);
        wr(17'h00501, 8'h77, 1'b0);
        rdchk(17'h00501, 1'b0, 8'h77);
    endtask

    task automatic t_id;
        int n;
        send(op_write, 17'h00005, 8'h42, 1'b1, 1'b1, 1'b0);
        wait_done(1'b0, n);
        rdchk(17'h00005, 1'b1, 8'h42);
        rdchk(17'h1FF85, 1'b0, 8'hFF);
    endtask

    initial
    begin
        #300000;
        err_total++;
        end_sim;
    end

    initial
    begin
        err_total = 0;
        checks_done = 0;
        rst_in = 1'b1;
        slow = 1'b0;
        cmd_valid_in = 1'b0;
        cmd_op_in = op_read;
        cmd_addr_in = 17'h00000;
        cmd_data_in = 8'h00;
        cmd_last_in = 1'b0;
        cmd_id_in = 1'b0;
        cmd_guard_in = 1'b0;
        repeat (10) @(posedge clk_in);
        chk("busy_in_reset", 17'(busy_out), 17'h1);
        rst_in <= 1'b0;
        repeat (20) @(negedge clk_in);
        chk("lockout_ready", 17'(cmd_ready_out), 17'h0);
        t_page;
        t_window;
        t_slow;
        t_lock;
        t_id;
        end_sim;
    end
endmodule
